// ===== verilog/mrat_ctrl.sv
// Controller end: issues commands while keeping every spacing of the access rules
`timescale 1ns/1ps
module mrat_ctrl
  import mrat_pkg::*;
// Notes on behaviour
// (R1) Config write allowed idle or banks active
// (R2) Config access leaves bank state unchanged
// (R3) Config read to write gap, termination off
// (R4) Config read to write gap, termination on
// (R5) Config read to config write gap
// (R6) Write to config read turnaround gap
// (R7) Powerdown exit plus wake before config read
// (R8) Read to config write gap
// (R9) Autoprecharge read adds precharge minus eight
// (R10) Write to config write gap
// (R11) Autoprecharge write adds write recovery
// (R12) High current bit set enables mode
// (R13) High current bit cleared disables mode
// (R14) Only deselects during high current wait
// (R15) Enable wait is 200 ns
// (R16) Disable wait is 100 ns
// (R17) Reference changes accepted without high current
// (R18) Config read waits half burst after read
// (R19) Only deselects during read period
// (R20) Config writes spaced by write cycle
// (R21) Writes to read-only registers ignored
// (R22) Config write then set delay before accesses
#(
  parameter int unsigned READ_LATENCY    = READ_LATENCY_DEF,
  parameter int unsigned WRITE_LATENCY   = WRITE_LATENCY_DEF,
  parameter int unsigned BURST_LENGTH    = BURST_LENGTH_DEF,
  parameter int unsigned STROBE_DELAY    = STROBE_DELAY_DEF,
  parameter int unsigned READ_POSTAMBLE  = READ_POSTAMBLE_DEF,
  parameter int unsigned WRITE_PREAMBLE  = WRITE_PREAMBLE_DEF,
  parameter int unsigned TERM_ON_LAT     = TERM_ON_LAT_DEF,
  parameter int unsigned TERM_ON_TIME    = TERM_ON_TIME_DEF,
  parameter int unsigned WTR_CYC         = WTR_CYC_DEF,
  parameter int unsigned WR_RECOVERY     = WR_RECOVERY_DEF,
  parameter int unsigned RTP_CYC         = RTP_CYC_DEF,
  parameter int unsigned REG_READ_PERIOD = REG_READ_PERIOD_DEF,
  parameter int unsigned REG_SET_DELAY   = REG_SET_DELAY_DEF,
  parameter int unsigned REG_WRITE_CYCLE = REG_WRITE_CYCLE_DEF,
  parameter int unsigned PD_EXIT         = PD_EXIT_DEF,
  parameter int unsigned REG_READ_WAKE   = REG_READ_WAKE_DEF
) (
  // Clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              RST_N,
  // User request
  input  wire logic              REQ_VALID,
  input  wire mrat_cmd_e         REQ_CMD,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  input  wire logic [DATA_W-1:0] REQ_WDATA,
  input  wire logic              TERM_EN,
  output logic                   REQ_READY,
  // Read answer
  output logic                   RESP_VALID,
  output logic [DATA_W-1:0]      RESP_DATA,
  // Link
  mrat_if.ctrl                   LINK
);

  localparam int unsigned HALF_BL  = BURST_LENGTH / 2;
  localparam int unsigned GAP78    = gap_cycles(GAP_MIN_PS, GAP_MIN_NCK);
  localparam int signed   RD2W_OFF = int'(READ_LATENCY + STROBE_DELAY + HALF_BL)
                                   - int'(WRITE_LATENCY) + int'(WRITE_PREAMBLE)
                                   + int'(READ_POSTAMBLE);
  localparam int signed   RD2W_ON  = int'(READ_LATENCY + STROBE_DELAY + HALF_BL)
                                   - int'(TERM_ON_LAT) - int'(TERM_ON_TIME)
                                   + int'(READ_POSTAMBLE) + int'(RD2W_ODT_EXTRA);
  localparam int unsigned RD2MRW   = READ_LATENCY + STROBE_DELAY + HALF_BL + MRR2MRW_EXTRA;
  localparam int unsigned WR2MRR   = WRITE_LATENCY + WR_EXTRA + HALF_BL + WTR_CYC;
  localparam int unsigned PD2MRR   = PD_EXIT + REG_READ_WAKE;
  localparam int unsigned R2MRW    = READ_LATENCY + HALF_BL + STROBE_DELAY
                                   + READ_POSTAMBLE + GAP78;
  localparam int unsigned W2MRW    = WRITE_LATENCY + WR_EXTRA + HALF_BL + GAP78;

  // Clamp a signed cycle count to at least one
  function automatic logic [CNT_W-1:0] cyc(input int signed v);
    return (v < 1) ? CNT_W'(1) : CNT_W'(v);
  endfunction

  // Load a timer with the larger of its remaining count and a new one
  function automatic logic [CNT_W-1:0] maxc(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    return (a > b) ? a : b;
  endfunction

  // Remaining cycles before each class of command may go out
  logic [CNT_W-1:0] t_mrr_q, t_mrw_q, t_rd_q, t_wr_q, t_any_q;
  logic             hicur_q;
  logic             is_rd, is_wr, is_mrr, is_mrw, allowed, fire;

  assign is_rd  = (REQ_CMD == CMD_RD) || (REQ_CMD == CMD_RDA) ||
                  (REQ_CMD == CMD_RD_FIFO) || (REQ_CMD == CMD_RD_CAL);
  assign is_wr  = (REQ_CMD == CMD_WR) || (REQ_CMD == CMD_WRA) || (REQ_CMD == CMD_MWR) ||
                  (REQ_CMD == CMD_MWRA) || (REQ_CMD == CMD_WR_FIFO);
  assign is_mrr = (REQ_CMD == CMD_CFG_READ);
  assign is_mrw = (REQ_CMD == CMD_CFG_WRITE);

  // Gate a request on its class timer and the global deselect-only window
  always_comb begin
    allowed = (t_any_q == '0); // (R14) (R19)
    if (is_mrr) begin
      allowed = allowed && (t_mrr_q == '0);
    end else if (is_mrw) begin
      allowed = allowed && (t_mrw_q == '0); // (R1)
    end else if (is_rd) begin
      allowed = allowed && (t_rd_q == '0);
    end else if (is_wr) begin
      allowed = allowed && (t_wr_q == '0);
    end
    if (REQ_CMD == CMD_DES) begin
      allowed = 1'b1;
    end
  end

  assign REQ_READY = allowed;
  assign fire      = REQ_VALID && allowed && (REQ_CMD != CMD_DES);

  // Spacing timers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      t_mrr_q <= '0;
      t_mrw_q <= '0;
      t_rd_q  <= '0;
      t_wr_q  <= '0;
      t_any_q <= '0;
      hicur_q <= 1'b0;
    end else begin
      logic [CNT_W-1:0] nmrr, nmrw, nrd, write_recovery_cycles, nany;
      nmrr = (t_mrr_q == '0) ? '0 : t_mrr_q - CNT_W'(1);
      nmrw = (t_mrw_q == '0) ? '0 : t_mrw_q - CNT_W'(1);
      nrd  = (t_rd_q == '0) ? '0 : t_rd_q - CNT_W'(1);
      write_recovery_cycles  = (t_wr_q == '0) ? '0 : t_wr_q - CNT_W'(1);
      nany = (t_any_q == '0) ? '0 : t_any_q - CNT_W'(1);
      if (fire) begin
        if (is_mrr) begin
          nany = maxc(nany, cyc(int'(REG_READ_PERIOD) - 1)); // (R19)
          nmrr = maxc(nmrr, cyc(int'(REG_READ_PERIOD) - 1));
          nrd  = maxc(nrd, cyc(int'(REG_READ_PERIOD) - 1));
          write_recovery_cycles  = maxc(write_recovery_cycles, TERM_EN ? cyc(RD2W_ON - 1) : cyc(RD2W_OFF - 1)); // (R3) (R4)
          nmrw = maxc(nmrw, cyc(int'(RD2MRW) - 1)); // (R5)
        end else if (is_mrw) begin
          nmrr = maxc(nmrr, cyc(int'(REG_SET_DELAY) - 1)); // (R22)
          nrd  = maxc(nrd, cyc(int'(REG_SET_DELAY) - 1));
          write_recovery_cycles  = maxc(write_recovery_cycles, cyc(int'(REG_SET_DELAY) - 1));
          nmrw = maxc(nmrw, cyc(int'(REG_WRITE_CYCLE) - 1)); // (R20)
          if (REQ_ADDR == REG_VREF_CTRL &&
              REQ_WDATA[HICUR_BIT_POS] != hicur_q) begin
            nany = maxc(nany, REQ_WDATA[HICUR_BIT_POS] ?
                   cyc(int'(HICUR_ENABLE_CYC) - 1) : // (R14) (R15)
                   cyc(int'(HICUR_DISABLE_CYC) - 1)); // (R16)
          end
        end else if (is_rd) begin
          nmrr = maxc(nmrr, cyc(int'(HALF_BL) - 1)); // (R18)
          nmrw = maxc(nmrw, (REQ_CMD == CMD_RDA) ?
                 cyc(int'(R2MRW + RTP_CYC) - int'(RTP_OFFSET) - 1) : // (R9)
                 cyc(int'(R2MRW) - 1)); // (R8)
        end else if (is_wr) begin
          nmrr = maxc(nmrr, cyc(int'(WR2MRR) - 1)); // (R6)
          nmrw = maxc(nmrw, (REQ_CMD == CMD_WRA || REQ_CMD == CMD_MWRA) ?
                 cyc(int'(W2MRW + WR_RECOVERY) - 1) : // (R11)
                 cyc(int'(W2MRW) - 1)); // (R10)
        end else if (REQ_CMD == CMD_PD_EXIT) begin
          nmrr = maxc(nmrr, cyc(int'(PD2MRR) - 1)); // (R7)
        end
      end
      t_mrr_q <= nmrr;
      t_mrw_q <= nmrw;
      t_rd_q  <= nrd;
      t_wr_q  <= write_recovery_cycles;
      t_any_q <= nany;
      if (fire && is_mrw && REQ_ADDR == REG_VREF_CTRL) begin
        hicur_q <= REQ_WDATA[HICUR_BIT_POS]; // (R12) (R13)
      end
    end
  end

  // Link drive registered from the accepted request
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      LINK.cmd   <= CMD_DES;
      LINK.addr  <= '0;
      LINK.wdata <= '0;
    end else begin
      LINK.cmd   <= fire ? REQ_CMD : CMD_DES;
      LINK.addr  <= REQ_ADDR;
      LINK.wdata <= REQ_WDATA;
    end
  end

  // Read answer capture
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      RESP_VALID <= 1'b0;
      RESP_DATA  <= '0;
    end else begin
      RESP_VALID <= LINK.rvalid;
      if (LINK.rvalid) begin
        RESP_DATA <= LINK.rdata;
      end
    end
  end

endmodule

// ===== verilog/mrat_pkg.sv
// Shared constants, command codes and timing counts for the mode register access link
package mrat_pkg;

  // Clock period in ps
  localparam int unsigned CLK_PERIOD_PS = 10000;

  // Command codes on the link
  typedef enum logic [3:0] {
    CMD_DES        = 4'h0,
    CMD_ACT        = 4'h1,
    CMD_PRE        = 4'h2,
    CMD_RD         = 4'h3,
    CMD_RDA        = 4'h4,
    CMD_WR         = 4'h5,
    CMD_WRA        = 4'h6,
    CMD_MWR        = 4'h7,
    CMD_MWRA       = 4'h8,
    CMD_RD_FIFO    = 4'h9,
    CMD_WR_FIFO    = 4'hA,
    CMD_RD_CAL     = 4'hB,
    CMD_CFG_READ   = 4'hC,
    CMD_CFG_WRITE  = 4'hD,
    CMD_PD_EXIT    = 4'hE
  } mrat_cmd_e;

  // Device bank state
  typedef enum logic [1:0] {
    BS_IDLE,
    BS_ACTIVE,
    BS_READING,
    BS_WRITING
  } mrat_bank_e;

  // Register address and data widths
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  // Control register holding the high current mode bit
  localparam logic [5:0] REG_VREF_CTRL      = 6'h0D;
  localparam int unsigned HICUR_BIT_POS     = 3;
  localparam logic [7:0] VREF_CTRL_RST      = 8'h00;
  // Command-bus and data-bus reference registers
  localparam logic [5:0] REG_VREF_CA        = 6'h0C;
  localparam logic [5:0] REG_VREF_DQ        = 6'h0E;
  // Read-only registers lie at and above this address
  localparam logic [5:0] REG_RO_BASE        = 6'h20;

  // Fixed figures of the spacing formulas
  localparam int unsigned RD2W_ODT_EXTRA    = 1;
  localparam int unsigned MRR2MRW_EXTRA     = 3;
  localparam int unsigned WR_EXTRA          = 1;
  localparam int unsigned RTP_OFFSET        = 8;
  localparam int unsigned GAP_MIN_NCK       = 8;
  localparam int unsigned GAP_MIN_PS        = 7500;

  // High current mode waits in ns, and cycles (longest time, rounded down)
  localparam int unsigned HICUR_ENABLE_NS   = 200;
  localparam int unsigned HICUR_DISABLE_NS  = 100;
  localparam int unsigned HICUR_ENABLE_CYC  = (HICUR_ENABLE_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned HICUR_DISABLE_CYC = (HICUR_DISABLE_NS * 1000) / CLK_PERIOD_PS;

  // Default latencies and delays in cycles
  localparam int unsigned READ_LATENCY_DEF      = 14;
  localparam int unsigned WRITE_LATENCY_DEF     = 8;
  localparam int unsigned BURST_LENGTH_DEF      = 16;
  localparam int unsigned STROBE_DELAY_DEF      = 2;
  localparam int unsigned READ_POSTAMBLE_DEF    = 0;
  localparam int unsigned WRITE_PREAMBLE_DEF    = 2;
  localparam int unsigned TERM_ON_LAT_DEF       = 6;
  localparam int unsigned TERM_ON_TIME_DEF      = 1;
  localparam int unsigned WTR_CYC_DEF           = 8;
  localparam int unsigned WR_RECOVERY_DEF       = 12;
  localparam int unsigned RTP_CYC_DEF           = 8;
  localparam int unsigned REG_READ_PERIOD_DEF   = 8;
  localparam int unsigned REG_SET_DELAY_DEF     = 10;
  localparam int unsigned REG_WRITE_CYCLE_DEF   = 10;
  localparam int unsigned PD_EXIT_DEF           = 2;
  localparam int unsigned REG_READ_WAKE_DEF     = 2;

  // Counter width for spacing timers
  localparam int unsigned CNT_W = 8;

  // Larger of a time in ps rounded up to cycles and a least count
  function automatic int unsigned gap_cycles(input int unsigned ps, input int unsigned nck);
    int unsigned c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c > nck) ? c : nck;
  endfunction

endpackage

// ===== verilog/mrat_if.sv
// Command and data link between controller and device
`timescale 1ns/1ps
interface mrat_if;
  import mrat_pkg::*;
  mrat_cmd_e         cmd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              rvalid;

  modport ctrl (output cmd, output addr, output wdata, input rdata, input rvalid);
  modport dev  (input cmd, input addr, input wdata, output rdata, output rvalid);
endinterface

// ===== verilog/mrat_dev.sv
// Device end: bank state, mode register store and reference generator mode
`timescale 1ns/1ps
module mrat_dev
  import mrat_pkg::*;
#(
  parameter int unsigned READ_LATENCY = READ_LATENCY_DEF
) (
  // Clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              RST_N,
  // Link
  mrat_if.dev                    LINK,
  // Device status
  output logic                   BANKS_ACTIVE,
  output logic                   CFG_ACCESS_BUSY,
  output logic                   HICUR_MODE,
  output logic [DATA_W-1:0]      VREF_CA_VAL,
  output logic [DATA_W-1:0]      VREF_DQ_VAL
);

  logic [DATA_W-1:0] regs_q [0:(1<<ADDR_W)-1];
  mrat_bank_e        state_q;
  logic              resume_active_q;
  logic [CNT_W-1:0]  lat_q;
  logic [DATA_W-1:0] rdata_q;
  logic              rvalid_q;
  logic              ro_hit;

  assign ro_hit = (LINK.addr >= REG_RO_BASE);

  // Bank state; access returns to the state it came from
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_q         <= BS_IDLE;
      resume_active_q <= 1'b0;
      lat_q           <= '0;
    end else begin
      case (state_q)
        BS_IDLE, BS_ACTIVE: begin
          if (LINK.cmd == CMD_CFG_READ || LINK.cmd == CMD_CFG_WRITE) begin // (R1)
            resume_active_q <= (state_q == BS_ACTIVE); // (R2)
            state_q <= (LINK.cmd == CMD_CFG_READ) ? BS_READING : BS_WRITING;
            lat_q   <= (LINK.cmd == CMD_CFG_READ) ? CNT_W'(READ_LATENCY) : CNT_W'(1);
          end else if (LINK.cmd == CMD_ACT) begin
            state_q <= BS_ACTIVE;
          end else if (LINK.cmd == CMD_PRE) begin
            state_q <= BS_IDLE;
          end
        end
        BS_READING, BS_WRITING: begin
          if (lat_q <= CNT_W'(1)) begin
            state_q <= resume_active_q ? BS_ACTIVE : BS_IDLE; // (R2)
          end
          lat_q <= (lat_q == '0) ? '0 : lat_q - CNT_W'(1);
        end
        default: state_q <= BS_IDLE;
      endcase
    end
  end

  // Register store; writes to read-only registers are dropped
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      for (int i = 0; i < (1<<ADDR_W); i++) begin
        regs_q[i] <= '0;
      end
    end else if (LINK.cmd == CMD_CFG_WRITE && !ro_hit) begin // (R21)
      regs_q[LINK.addr] <= LINK.wdata; // (R17)
    end
  end

  // Read return after read latency
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= (state_q == BS_READING) && (lat_q == CNT_W'(1));
      if (LINK.cmd == CMD_CFG_READ) begin
        rdata_q <= regs_q[LINK.addr];
      end
    end
  end

  // Outputs
  assign LINK.rdata      = rdata_q;
  assign LINK.rvalid     = rvalid_q;
  assign BANKS_ACTIVE    = (state_q == BS_ACTIVE) ||
                           ((state_q == BS_READING || state_q == BS_WRITING) && resume_active_q);
  assign CFG_ACCESS_BUSY = (state_q == BS_READING) || (state_q == BS_WRITING);
  assign HICUR_MODE      = regs_q[REG_VREF_CTRL][HICUR_BIT_POS]; // (R12) (R13)
  assign VREF_CA_VAL     = regs_q[REG_VREF_CA]; // (R17)
  assign VREF_DQ_VAL     = regs_q[REG_VREF_DQ];

endmodule

// ===== tb/mrat_chk.sv
// Concurrent checks on the link between controller and device ends
`timescale 1ns/1ps
module mrat_chk
  import mrat_pkg::*;
(
  // Clock and reset
  input wire logic              CLK_SYS,
  input wire logic              RST_N,
  // Link
  input wire mrat_cmd_e         cmd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata
);
  localparam int GC    = (GAP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int G     = (GC > GAP_MIN_NCK) ? GC : GAP_MIN_NCK;
  localparam int RDX   = READ_LATENCY_DEF + STROBE_DELAY_DEF + BURST_LENGTH_DEF / 2;
  localparam int WRX   = WRITE_LATENCY_DEF + WR_EXTRA + BURST_LENGTH_DEF / 2;
  localparam int T_OFF = RDX - WRITE_LATENCY_DEF + WRITE_PREAMBLE_DEF + READ_POSTAMBLE_DEF;
  localparam int T_ON  = RDX - TERM_ON_LAT_DEF - TERM_ON_TIME_DEF + READ_POSTAMBLE_DEF + 1;
  localparam int T_RW  = (T_OFF < T_ON) ? T_OFF : T_ON;
  localparam int T_RDW = RDX + READ_POSTAMBLE_DEF + G;

  logic [7:0] mrr_q, mrw_q, rd_q, rda_q, wr_q, wra_q, pdx_q, hold_q;
  logic       hicur_q;
  logic       flip;

  function automatic logic [7:0] age(input logic hit, input logic [7:0] c);
    return hit ? 8'h01 : ((c == 8'hFF) ? c : c + 8'h01);
  endfunction

  // Cycles since the last command of each class, saturating
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      mrr_q <= 8'hFF;
      mrw_q <= 8'hFF;
      rd_q  <= 8'hFF;
      rda_q <= 8'hFF;
      wr_q  <= 8'hFF;
      wra_q <= 8'hFF;
      pdx_q <= 8'hFF;
    end else begin
      mrr_q <= age(cmd == CMD_CFG_READ, mrr_q);
      mrw_q <= age(cmd == CMD_CFG_WRITE, mrw_q);
      rd_q  <= age(cmd inside {CMD_RD, CMD_RD_FIFO, CMD_RD_CAL}, rd_q);
      rda_q <= age(cmd == CMD_RDA, rda_q);
      wr_q  <= age(cmd inside {CMD_WR, CMD_MWR, CMD_WR_FIFO}, wr_q);
      wra_q <= age(cmd inside {CMD_WRA, CMD_MWRA}, wra_q);
      pdx_q <= age(cmd == CMD_PD_EXIT, pdx_q);
    end
  end

  // A write that changes the high current bit opens a deselect-only wait
  assign flip = cmd == CMD_CFG_WRITE && addr == REG_VREF_CTRL && wdata[HICUR_BIT_POS] != hicur_q;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      hold_q  <= 8'h00;
      hicur_q <= 1'b0;
    end else if (flip) begin
      hicur_q <= wdata[HICUR_BIT_POS];
      hold_q  <= wdata[HICUR_BIT_POS] ? 8'(HICUR_ENABLE_CYC - 1) : 8'(HICUR_DISABLE_CYC - 1);
    end else if (hold_q != 8'h00) begin
      hold_q <= hold_q - 8'h01;
    end
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  AST_READ_QUIET: assert property (cmd == CMD_CFG_READ |=> (cmd == CMD_DES)[*7])
    else $error("command inside read period");
  AST_READ_TO_WR: assert property (cmd inside {CMD_WR, CMD_WRA, CMD_MWR, CMD_MWRA} |-> mrr_q >= T_RW)
    else $error("write too soon after config read");
  AST_READ_TO_CFGW: assert property (cmd == CMD_CFG_WRITE |-> mrr_q >= RDX + 3)
    else $error("config write too soon after config read");
  AST_WR_TO_READ: assert property (cmd == CMD_CFG_READ |-> wr_q >= WRX + WTR_CYC_DEF && wra_q >= WRX + WTR_CYC_DEF)
    else $error("config read too soon after write");
  AST_PDX_TO_READ: assert property (cmd == CMD_CFG_READ |-> pdx_q >= PD_EXIT_DEF + REG_READ_WAKE_DEF)
    else $error("config read too soon after powerdown exit");
  AST_RD_TO_CFGW: assert property (cmd == CMD_CFG_WRITE |-> rd_q >= T_RDW)
    else $error("config write too soon after read");
  AST_RDA_TO_CFGW: assert property (cmd == CMD_CFG_WRITE |-> rda_q >= T_RDW + RTP_CYC_DEF - RTP_OFFSET)
    else $error("config write too soon after autoprecharge read");
  AST_WR_TO_CFGW: assert property (cmd == CMD_CFG_WRITE |-> wr_q >= WRX + G)
    else $error("config write too soon after write");
  AST_WRA_TO_CFGW: assert property (cmd == CMD_CFG_WRITE |-> wra_q >= WRX + G + WR_RECOVERY_DEF)
    else $error("config write too soon after autoprecharge write");
  AST_HICUR_QUIET: assert property (cmd != CMD_DES |-> hold_q == 8'h00)
    else $error("command inside high current wait");
  AST_RD_TO_READ: assert property (cmd == CMD_CFG_READ |-> rd_q >= BURST_LENGTH_DEF / 2 && rda_q >= BURST_LENGTH_DEF / 2)
    else $error("config read too soon after read");
  AST_CFGW_SPACING: assert property (cmd == CMD_CFG_WRITE |-> mrw_q >= REG_WRITE_CYCLE_DEF)
    else $error("config writes too close");
  AST_SET_DELAY: assert property (cmd inside {CMD_CFG_READ, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA} |-> mrw_q >= REG_SET_DELAY_DEF)
    else $error("access too soon after config write");
endmodule

// ===== tb/mrat_test.sv
// Self-checking bench joining controller and device ends
`timescale 1ns/1ps
module mode_register_access_timing_test;
  import mrat_pkg::*;
  localparam int GC  = (GAP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int G   = (GC > GAP_MIN_NCK) ? GC : GAP_MIN_NCK;
  localparam int RDX = READ_LATENCY_DEF + STROBE_DELAY_DEF + BURST_LENGTH_DEF / 2;
  localparam int WRX = WRITE_LATENCY_DEF + WR_EXTRA + BURST_LENGTH_DEF / 2;
  localparam int T_RDW = RDX + READ_POSTAMBLE_DEF + G;

  logic              clk_sys   = 1'b0;
  logic              rst_n     = 1'b0;
  logic              req_valid = 1'b0;
  logic              term_en   = 1'b0;
  mrat_cmd_e         req_cmd   = CMD_DES;
  logic [ADDR_W-1:0] req_addr  = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic              req_ready, resp_valid, banks_active, busy, hicur;
  logic [DATA_W-1:0] resp_data, vref_ca, vref_dq;
  int                bad_count = 0;
  int                n_tests   = 0;

  mrat_if mrat_if_inst ();
  mrat_ctrl mrat_ctrl_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .REQ_VALID(req_valid),
    .REQ_CMD(req_cmd), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .TERM_EN(term_en),
    .REQ_READY(req_ready), .RESP_VALID(resp_valid), .RESP_DATA(resp_data),
    .LINK(mrat_if_inst.ctrl));
  mrat_dev mrat_dev_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .LINK(mrat_if_inst.dev),
    .BANKS_ACTIVE(banks_active), .CFG_ACCESS_BUSY(busy), .HICUR_MODE(hicur),
    .VREF_CA_VAL(vref_ca), .VREF_DQ_VAL(vref_dq));
  mrat_chk mrat_chk_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .cmd(mrat_if_inst.cmd),
    .addr(mrat_if_inst.addr), .wdata(mrat_if_inst.wdata));

  // Clock
  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hold a request until its take edge; n counts edges waited
  task automatic issue(input mrat_cmd_e c, input logic [5:0] a, input logic [7:0] d,
                       output int n);
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_addr  <= a;
    req_wdata <= d;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n > 200) begin
        bad_count++;
        tally_and_finish();
      end
    end while (req_ready !== 1'b1);
    @(posedge clk_sys);
  endtask

  task automatic idle();
    req_valid <= 1'b0;
    req_cmd   <= CMD_DES;
  endtask

  // Spacing from a taken command to the next one
  task automatic pair(input mrat_cmd_e a, input mrat_cmd_e b, input logic t, input int e);
    int n;
    term_en <= t;
    issue(a, REG_VREF_CA, 8'h11, n);
    issue(b, REG_VREF_CA, 8'h22, n);
    idle();
    chk(n, e);
    repeat (40) @(posedge clk_sys);
  endtask

  // Config read; answer latency is checked on the way
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    int n;
    issue(CMD_CFG_READ, a, 8'h00, n);
    idle();
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n > 100) begin
        bad_count++;
        tally_and_finish();
      end
    end while (resp_valid !== 1'b1);
    // Answer at take edge plus latency plus 2; n counts the negedge after it
    chk(n, READ_LATENCY_DEF + 3);
    d = resp_data;
    @(posedge clk_sys);
  endtask

  task automatic sc_gaps();
    pair(CMD_CFG_READ, CMD_CFG_WRITE, 1'b0, RDX + 3);
    pair(CMD_CFG_READ, CMD_WR, 1'b0, RDX - WRITE_LATENCY_DEF + WRITE_PREAMBLE_DEF);
    pair(CMD_CFG_READ, CMD_MWRA, 1'b1, RDX - TERM_ON_LAT_DEF - TERM_ON_TIME_DEF + 1);
    pair(CMD_CFG_READ, CMD_RD, 1'b0, REG_READ_PERIOD_DEF);
    pair(CMD_CFG_READ, CMD_CFG_READ, 1'b0, REG_READ_PERIOD_DEF);
    pair(CMD_WRA, CMD_CFG_READ, 1'b0, WRX + WTR_CYC_DEF);
    pair(CMD_MWR, CMD_CFG_READ, 1'b0, WRX + WTR_CYC_DEF);
    pair(CMD_PD_EXIT, CMD_CFG_READ, 1'b0, PD_EXIT_DEF + REG_READ_WAKE_DEF);
    pair(CMD_RD, CMD_CFG_READ, 1'b0, BURST_LENGTH_DEF / 2);
    pair(CMD_RD, CMD_CFG_WRITE, 1'b0, T_RDW);
    pair(CMD_RD_FIFO, CMD_CFG_WRITE, 1'b0, T_RDW);
    pair(CMD_RD_CAL, CMD_CFG_WRITE, 1'b0, T_RDW);
    pair(CMD_RDA, CMD_CFG_WRITE, 1'b0, T_RDW + RTP_CYC_DEF - 8);
    pair(CMD_WR, CMD_CFG_WRITE, 1'b0, WRX + G);
    pair(CMD_WR_FIFO, CMD_CFG_WRITE, 1'b0, WRX + G);
    pair(CMD_MWRA, CMD_CFG_WRITE, 1'b0, WRX + G + WR_RECOVERY_DEF);
    pair(CMD_CFG_WRITE, CMD_CFG_WRITE, 1'b0, REG_WRITE_CYCLE_DEF);
    pair(CMD_CFG_WRITE, CMD_CFG_READ, 1'b0, REG_SET_DELAY_DEF);
    pair(CMD_CFG_WRITE, CMD_WRA, 1'b0, REG_SET_DELAY_DEF);
  endtask

  task automatic sc_regs();
    int n;
    logic [7:0] d0, d1;
    issue(CMD_CFG_WRITE, REG_VREF_CTRL, 8'h08, n);
    issue(CMD_CFG_READ, REG_VREF_CTRL, 8'h00, n);
    idle();
    chk(n, HICUR_ENABLE_CYC);
    repeat (40) @(posedge clk_sys);
    chk(hicur, 1'b1);
    rd_reg(REG_VREF_CTRL, d0);
    chk(d0, 8'h08);
    issue(CMD_CFG_WRITE, REG_VREF_CTRL, 8'h00, n);
    issue(CMD_RD, REG_VREF_CTRL, 8'h00, n);
    idle();
    chk(n, HICUR_DISABLE_CYC);
    repeat (40) @(posedge clk_sys);
    chk(hicur, 1'b0);
    issue(CMD_CFG_WRITE, REG_VREF_DQ, 8'hA5, n);
    idle();
    rd_reg(REG_VREF_DQ, d0);
    chk(d0, 8'hA5);
    chk(vref_dq, 8'hA5);
    rd_reg(REG_RO_BASE, d0);
    issue(CMD_CFG_WRITE, REG_RO_BASE, ~d0, n);
    idle();
    rd_reg(REG_RO_BASE, d1);
    chk(d1, d0);
  endtask

  // Config write from active and from idle banks
  task automatic sc_banks(input mrat_cmd_e c, input logic act, input logic [7:0] d);
    int n;
    logic seen;
    issue(c, 6'h00, 8'h00, n);
    issue(CMD_CFG_WRITE, REG_VREF_CA, d, n);
    idle();
    seen = 1'b0;
    repeat (4) begin
      @(negedge clk_sys);
      seen = seen | (busy === 1'b1);
      chk(banks_active, act);
    end
    chk(seen, 1'b1);
    repeat (12) @(negedge clk_sys);
    chk(banks_active, act);
    chk(vref_ca, d);
    @(posedge clk_sys);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk(req_ready, 1'b1);
    chk(mrat_if_inst.cmd, CMD_DES);
    @(posedge clk_sys);
    sc_gaps();
    sc_regs();
    sc_banks(CMD_ACT, 1'b1, 8'h33);
    sc_banks(CMD_PRE, 1'b0, 8'h44);
    tally_and_finish();
  end
endmodule
